// ### mc_pkg.sv
package mc_pkg;
	// Timing
	localparam int CLK_NS        = 100;
	localparam int PWM_PERIOD_NS = 50000;
	localparam int PERIOD_CYC    = PWM_PERIOD_NS / CLK_NS;
	localparam int HALF_CYC      = PERIOD_CYC / 2;
	localparam int QTR_CYC       = HALF_CYC / 2;
	localparam int SC_DIV        = 2;
	localparam int FW            = 9;
	localparam int DW            = 24;
	localparam int FRAC          = 23;
	localparam int GAIN_FRAC     = 15;
	localparam int SEC_PER_REV   = 6;
	localparam int DIV_STEPS     = 24;
	localparam int SC_LEN        = DIV_STEPS + 2;
	localparam int HALL_LEN      = 2;
	localparam int WIDE_LEN      = 3;
	// Register offsets
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_SETP   = 8'h04;
	localparam logic [7:0] A_KP     = 8'h08;
	localparam logic [7:0] A_KI     = 8'h0c;
	localparam logic [7:0] A_STEP   = 8'h10;
	localparam logic [7:0] A_LEAD   = 8'h14;
	localparam logic [7:0] A_SCOFS  = 8'h18;
	localparam logic [7:0] A_SCALE  = 8'h1c;
	localparam logic [7:0] A_STAT   = 8'h20;
	localparam logic [7:0] A_REVCNT = 8'h24;
	localparam logic [7:0] A_REVPER = 8'h28;
	localparam logic [7:0] A_SECPER = 8'h2c;
	localparam logic [7:0] A_EDGE   = 8'h30;
	localparam logic [7:0] A_SPEED  = 8'h34;
	localparam logic [7:0] A_VOLT   = 8'h38;
	// Field positions
	localparam int CTRL_EN     = 0;
	localparam int CTRL_CLOSED = 1;
	localparam int CTRL_SECSEL = 2;
	localparam int ST_DIR      = 3;
	localparam int ST_PEND     = 4;
	// Reset values
	localparam logic [8:0]  LEAD_RST  = 9'h014;
	localparam logic [8:0]  SCOFS_RST = 9'h040;
	localparam logic [23:0] KP_RST    = 24'h008000;
	localparam logic [23:0] KI_RST    = 24'h000800;
	localparam logic [23:0] STEP_RST  = 24'h000400;
	localparam logic [23:0] SCALE_RST = 24'h400000;
	typedef enum logic [2:0] {SV_IDLE, SV_HALL, SV_MUPD, SV_MREQ, SV_SC} svc_e;
endpackage

// ### phase_bus_if.sv
`timescale 1ns/1ns
interface phase_bus_if;
	logic [mc_pkg::FW-1:0] frame;
	logic [mc_pkg::FW-1:0] duty_pos;
	logic [mc_pkg::FW-1:0] duty_neg;
	logic [2:0]            on;
	logic [2:0]            neg;
	modport ctl (output frame, duty_pos, duty_neg, on, neg);
	modport gen (input frame, duty_pos, duty_neg, on, neg);
endinterface

// ### commuted_phase_gen.sv
`timescale 1ns/1ns
module commuted_phase_gen #(
	parameter int IDX = 0
) (
	// Clock and reset
	input  wire logic  clk,
	input  wire logic  rst,
	// Commands from the master
	phase_bus_if.gen   bus,
	// Pins
	output logic       base_q,
	output logic       comp_q
);
	localparam logic [8:0] LAST_F = 9'(mc_pkg::PERIOD_CYC - 1);
	localparam logic [8:0] HALF_F = 9'(mc_pkg::HALF_CYC);

	logic [8:0] tri_w;
	logic [8:0] duty_w;
	logic       act_w;

	// Triangle peaks mid-frame, so the pulse sits centred in the period
	assign tri_w  = (bus.frame < HALF_F) ? bus.frame : LAST_F - bus.frame;
	assign duty_w = bus.neg[IDX] ? bus.duty_neg : bus.duty_pos;
	assign act_w  = tri_w >= (HALF_F - duty_w);

	// Base active-high; complementary follows base, so it is low while base is idle
	always_ff @(posedge clk) begin
		if (rst || !bus.on[IDX]) begin
			base_q <= 1'b0;
			comp_q <= 1'b0;
		end else begin
			base_q <= act_w;
			comp_q <= act_w;
		end
	end

	off_low_a: assert property (@(posedge clk) disable iff (rst)
		!bus.on[IDX] |=> !base_q && !comp_q)
		else $error("phase not low while switched off");
endmodule // commuted_phase_gen

// ### bldc_motor_ctl.sv
// Behaviour
// - Master computes duty, updates three phases, no pin
// - Sector decoded from three adjacent Hall inputs
// - Direction zero means incremental, else decremental
// - Revolution counter steps once per revolution, signed
// - Revolution period from same-polarity same-channel edge
// - Sector period from previous edge on any channel
// - Timebase captured at every Hall edge
// - Each Hall transition commutes phases by direction
// - Speed PI from measured and required speed
// - Required speed ramps toward host setpoint
// - Services run to completion, priority waiting
// - Phase service latency below one PWM period
// - Activity pins high exactly during service
// - Centre-aligned pair, base high, complement identical to base
// - PWM period fifty microseconds, twenty kilohertz
// - Speed loop runs every second PWM period
// - Master services request; reloads duty when pending
// - Update scheduled lead time before frame end
// - Speed loop placed ahead of master update
// - Hall edges accepted any time, frame-independent
// - Speed from revolution period, sector optionally
// - Transition applies phase-off then phase-on command
`timescale 1ns/1ns
module bldc_motor_ctl (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Register port
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [31:0] rdata,
	// Hall sensors
	input  wire logic [2:0]  hall,
	// Power stage
	output logic      [2:0]  phase_base,
	output logic      [2:0]  phase_comp,
	// Activity pins
	output logic             sc_act,
	output logic             master_act
);
	localparam logic [8:0]         LAST_F = 9'(mc_pkg::PERIOD_CYC - 1);
	localparam logic signed [48:0] MAXV   = 49'sh07fffff;
	localparam logic signed [48:0] MINV   = -49'sh0800000;

	function automatic logic [2:0] sector_of(input logic [2:0] h);
		case (h)
			3'h1: sector_of = 3'h0;
			3'h3: sector_of = 3'h1;
			3'h2: sector_of = 3'h2;
			3'h6: sector_of = 3'h3;
			3'h4: sector_of = 3'h4;
			3'h5: sector_of = 3'h5;
			default: sector_of = 3'h7;
		endcase
	endfunction

	function automatic logic [2:0] nxt(input logic [2:0] s);
		nxt = (s == 3'h5) ? 3'h0 : s + 3'h1;
	endfunction

	function automatic logic [1:0] pos_ph(input logic [2:0] s);
		pos_ph = s[2:1];
	endfunction

	function automatic logic [1:0] neg_ph(input logic [2:0] s);
		if (s == 3'h0 || s == 3'h5)
			neg_ph = 2'h1;
		else
			neg_ph = (s < 3'h3) ? 2'h2 : 2'h0;
	endfunction

	function automatic logic signed [23:0] sat24(input logic signed [48:0] x);
		if (x > MAXV)
			sat24 = 24'sh7fffff;
		else if (x < MINV)
			sat24 = 24'sh800000;
		else
			sat24 = 24'(x);
	endfunction

	function automatic logic [8:0] duty_of(input logic signed [23:0] v);
		logic signed [33:0] p;
		p = v * $signed(11'(mc_pkg::QTR_CYC));
		duty_of = 9'(mc_pkg::QTR_CYC) + 9'(p >>> mc_pkg::FRAC);
	endfunction

	// Control registers
	logic               en_q, closed_q, secsel_q;
	logic signed [23:0] setp_q, kp_q, ki_q, step_q;
	logic        [23:0] scale_q;
	logic        [8:0]  lead_q, scofs_q;
	// Frame and timebase
	logic        [8:0]  frame_q, upd_at;
	logic        [1:0]  scdiv_q;
	logic        [23:0] tb_q;
	// Hall decoder
	logic        [2:0]  hall_q, sector_q, ns, eidx;
	logic        [1:0]  ech;
	logic               hall_ev, dir_q;
	logic        [23:0] last_edge_q, rev_per_q, sec_per_q;
	logic        [23:0] edge_ts_q [6];
	logic signed [23:0] rev_cnt_q;
	// Service engine
	mc_pkg::svc_e       svc_q;
	logic        [4:0]  cnt_q;
	logic               rq_hall_q, rq_mupd_q, rq_mreq_q, rq_sc_q, idle;
	logic               g_hall, g_mupd, g_mreq, g_sc, sc_done, upd_hit, sc_hit;
	// Phases and master
	logic        [2:0]  on_q, neg_q;
	logic        [1:0]  pp, np, fp;
	logic        [8:0]  duty_pos_q, duty_neg_q;
	logic               pend_q;
	logic signed [23:0] new_v_q, volt_q;
	// Speed loop
	logic        [23:0] rem_q, quo_q, dvs_q;
	logic        [24:0] r2;
	logic               take;
	logic signed [23:0] req_q, speed_q, integ_q, ramp_d, err, int_d, out_d;
	logic signed [24:0] rdiff;
	logic signed [47:0] pmul, imul;

	phase_bus_if pb ();

	assign pb.frame    = frame_q;
	assign pb.duty_pos = duty_pos_q;
	assign pb.duty_neg = duty_neg_q;
	assign pb.on       = on_q;
	assign pb.neg      = neg_q;

	for (genvar g = 0; g < 3; g++) begin : g_ph
		commuted_phase_gen #(.IDX(g)) u_ph (
			.clk    (clk),
			.rst    (rst),
			.bus    (pb),
			.base_q (phase_base[g]),
			.comp_q (phase_comp[g])
		);
	end

	// Register writes
	always_ff @(posedge clk) begin
		if (rst) begin
			en_q     <= 1'b0;
			closed_q <= 1'b0;
			secsel_q <= 1'b0;
			setp_q   <= '0;
			kp_q     <= mc_pkg::KP_RST;
			ki_q     <= mc_pkg::KI_RST;
			step_q   <= mc_pkg::STEP_RST;
			lead_q   <= mc_pkg::LEAD_RST;
			scofs_q  <= mc_pkg::SCOFS_RST;
			scale_q  <= mc_pkg::SCALE_RST;
		end else if (wr) begin
			case (addr)
				mc_pkg::A_CTRL: begin
					en_q     <= wdata[mc_pkg::CTRL_EN];
					closed_q <= wdata[mc_pkg::CTRL_CLOSED];
					secsel_q <= wdata[mc_pkg::CTRL_SECSEL];
				end
				mc_pkg::A_SETP:  setp_q  <= wdata[23:0];
				mc_pkg::A_KP:    kp_q    <= wdata[23:0];
				mc_pkg::A_KI:    ki_q    <= wdata[23:0];
				mc_pkg::A_STEP:  step_q  <= wdata[23:0];
				mc_pkg::A_LEAD:  lead_q  <= wdata[8:0];
				mc_pkg::A_SCOFS: scofs_q <= wdata[8:0];
				mc_pkg::A_SCALE: scale_q <= wdata[23:0];
				default: ;
			endcase
		end
	end

	// Register reads; data stands one cycle, zero otherwise
	always_ff @(posedge clk) begin
		if (rst || !rd) begin
			rdata <= '0;
		end else begin
			rdata <= '0;
			case (addr)
				mc_pkg::A_CTRL: begin
					rdata[mc_pkg::CTRL_EN]     <= en_q;
					rdata[mc_pkg::CTRL_CLOSED] <= closed_q;
					rdata[mc_pkg::CTRL_SECSEL] <= secsel_q;
				end
				mc_pkg::A_SETP:   rdata[23:0] <= setp_q;
				mc_pkg::A_KP:     rdata[23:0] <= kp_q;
				mc_pkg::A_KI:     rdata[23:0] <= ki_q;
				mc_pkg::A_STEP:   rdata[23:0] <= step_q;
				mc_pkg::A_LEAD:   rdata[8:0]  <= lead_q;
				mc_pkg::A_SCOFS:  rdata[8:0]  <= scofs_q;
				mc_pkg::A_SCALE:  rdata[23:0] <= scale_q;
				mc_pkg::A_STAT: begin
					rdata[2:0]             <= sector_q;
					rdata[mc_pkg::ST_DIR]  <= dir_q;
					rdata[mc_pkg::ST_PEND] <= pend_q;
				end
				mc_pkg::A_REVCNT: rdata[23:0] <= rev_cnt_q;
				mc_pkg::A_REVPER: rdata[23:0] <= rev_per_q;
				mc_pkg::A_SECPER: rdata[23:0] <= sec_per_q;
				mc_pkg::A_EDGE:   rdata[23:0] <= last_edge_q;
				mc_pkg::A_SPEED:  rdata[23:0] <= speed_q;
				mc_pkg::A_VOLT:   rdata[23:0] <= volt_q;
				default: ;
			endcase
		end
	end

	// Timebase and PWM frame
	always_ff @(posedge clk) begin
		if (rst) begin
			tb_q    <= '0;
			frame_q <= '0;
			scdiv_q <= '0;
		end else begin
			tb_q    <= tb_q + 24'h1;
			frame_q <= (frame_q == LAST_F) ? 9'h000 : frame_q + 9'h001;
			if (frame_q == LAST_F)
				scdiv_q <= (scdiv_q == 2'(mc_pkg::SC_DIV - 1)) ? 2'h0 : scdiv_q + 2'h1;
		end
	end

	assign upd_at  = LAST_F - lead_q;
	assign upd_hit = en_q && frame_q == upd_at;
	// Speed loop runs scofs_q cycles earlier in the frame so, with the reset offset, its latency does not delay the update
	assign sc_hit  = en_q && scdiv_q == 2'(mc_pkg::SC_DIV - 1)
		&& frame_q == upd_at - scofs_q;

	// Hall edge capture works regardless of the frame
	assign hall_ev = hall != hall_q;
	assign ns      = sector_of(hall);
	assign ech     = (hall_q[0] ^ hall[0]) ? 2'h0 : ((hall_q[1] ^ hall[1]) ? 2'h1 : 2'h2);
	assign eidx    = {ech, hall[ech]};

	always_ff @(posedge clk) begin
		if (rst) begin
			hall_q      <= '0;
			sector_q    <= '0;
			dir_q       <= 1'b0;
			rev_cnt_q   <= '0;
			last_edge_q <= '0;
			rev_per_q   <= '0;
			sec_per_q   <= '0;
			for (int i = 0; i < 6; i++)
				edge_ts_q[i] <= '0;
		end else begin
			hall_q <= hall;
			if (hall_ev) begin
				last_edge_q     <= tb_q;
				sec_per_q       <= tb_q - last_edge_q;
				rev_per_q       <= tb_q - edge_ts_q[eidx];
				edge_ts_q[eidx] <= tb_q;
				// The edge seen at reset release lands in the same sector; no direction
				if (ns != 3'h7 && ns != sector_q) begin
					sector_q <= ns;
					dir_q    <= (ns == nxt(sector_q)) ? 1'b0 : 1'b1;
					if (ns == nxt(sector_q) && ns == 3'h0)
						rev_cnt_q <= rev_cnt_q + 24'sh1;
					else if (sector_q == nxt(ns) && sector_q == 3'h0)
						rev_cnt_q <= rev_cnt_q - 24'sh1;
				end
			end
		end
	end

	// Fixed priority among waiting requests; no preemption once started
	assign idle    = svc_q == mc_pkg::SV_IDLE;
	assign g_hall  = idle && rq_hall_q;
	assign g_mupd  = idle && !rq_hall_q && rq_mupd_q;
	assign g_mreq  = idle && !rq_hall_q && !rq_mupd_q && rq_mreq_q;
	assign g_sc    = idle && !rq_hall_q && !rq_mupd_q && !rq_mreq_q && rq_sc_q;
	assign sc_done = svc_q == mc_pkg::SV_SC && cnt_q == 5'h00;

	// A new request in its grant cycle stays pending
	always_ff @(posedge clk) begin
		if (rst) begin
			rq_hall_q <= 1'b0;
			rq_mupd_q <= 1'b0;
			rq_mreq_q <= 1'b0;
			rq_sc_q   <= 1'b0;
		end else begin
			rq_hall_q <= (hall_ev && en_q) || (rq_hall_q && !g_hall);
			rq_mupd_q <= upd_hit || (rq_mupd_q && !g_mupd);
			rq_mreq_q <= sc_done || (rq_mreq_q && !g_mreq);
			rq_sc_q   <= sc_hit || (rq_sc_q && !g_sc);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			svc_q <= mc_pkg::SV_IDLE;
			cnt_q <= '0;
		end else if (idle) begin
			if (g_hall) begin
				svc_q <= mc_pkg::SV_HALL;
				cnt_q <= 5'(mc_pkg::HALL_LEN - 1);
			end else if (g_mupd) begin
				svc_q <= mc_pkg::SV_MUPD;
				cnt_q <= pend_q ? 5'(mc_pkg::WIDE_LEN - 1) : 5'h00;
			end else if (g_mreq) begin
				svc_q <= mc_pkg::SV_MREQ;
				cnt_q <= 5'h00;
			end else if (g_sc) begin
				svc_q <= mc_pkg::SV_SC;
				cnt_q <= 5'(mc_pkg::SC_LEN - 1);
			end
		end else if (cnt_q == 5'h00) begin
			svc_q <= mc_pkg::SV_IDLE;
		end else begin
			cnt_q <= cnt_q - 5'h01;
		end
	end

	assign sc_act     = svc_q == mc_pkg::SV_SC;
	assign master_act = svc_q == mc_pkg::SV_MUPD || svc_q == mc_pkg::SV_MREQ;

	// Commutation: phase pair depends on sector and swaps with direction
	assign pp = dir_q ? neg_ph(sector_q) : pos_ph(sector_q);
	assign np = dir_q ? pos_ph(sector_q) : neg_ph(sector_q);
	assign fp = 2'h3 - pp - np;

	always_ff @(posedge clk) begin
		if (rst || !en_q) begin
			on_q  <= '0;
			neg_q <= '0;
		end else if (svc_q == mc_pkg::SV_HALL) begin
			if (cnt_q == 5'h01) begin
				on_q[fp] <= 1'b0;
			end else begin
				on_q[pp]  <= 1'b1;
				on_q[np]  <= 1'b1;
				neg_q[pp] <= 1'b0;
				neg_q[np] <= 1'b1;
			end
		end
	end

	// Master: takes the new voltage, reloads duty only at the frame update
	always_ff @(posedge clk) begin
		if (rst) begin
			pend_q     <= 1'b0;
			new_v_q    <= '0;
			duty_pos_q <= 9'(mc_pkg::QTR_CYC);
			duty_neg_q <= 9'(mc_pkg::QTR_CYC);
		end else if (g_mreq) begin
			new_v_q <= volt_q;
			pend_q  <= 1'b1;
		end else if (g_mupd && pend_q) begin
			duty_pos_q <= duty_of(new_v_q);
			duty_neg_q <= duty_of((new_v_q == 24'sh800000) ? 24'sh7fffff : -new_v_q);
			pend_q     <= 1'b0;
		end
	end

	// Speed loop datapath: serial divide, then ramp, then PI
	assign r2    = {rem_q, quo_q[23]};
	assign take  = r2 >= {1'b0, dvs_q};
	assign rdiff = 25'(setp_q) - 25'(req_q);
	assign ramp_d = (rdiff > 25'(step_q)) ? req_q + step_q
		: (rdiff < -25'(step_q)) ? req_q - step_q : setp_q;
	assign err   = sat24(49'(req_q) - 49'(speed_q));
	assign pmul  = kp_q * err;
	assign imul  = ki_q * err;
	assign int_d = sat24(49'(integ_q) + 49'(imul >>> mc_pkg::GAIN_FRAC));
	assign out_d = sat24(49'(pmul >>> mc_pkg::GAIN_FRAC) + 49'(int_d));

	always_ff @(posedge clk) begin
		if (rst || !en_q) begin
			dvs_q   <= '0;
			rem_q   <= '0;
			quo_q   <= '0;
			speed_q <= '0;
			req_q   <= '0;
			integ_q <= '0;
			volt_q  <= '0;
		end else if (g_sc) begin
			dvs_q <= secsel_q ? 24'(sec_per_q * 24'(mc_pkg::SEC_PER_REV)) : rev_per_q;
			rem_q <= '0;
			quo_q <= scale_q;
		end else if (svc_q == mc_pkg::SV_SC) begin
			if (cnt_q >= 5'h02) begin
				rem_q <= take ? 24'(r2 - {1'b0, dvs_q}) : r2[23:0];
				quo_q <= {quo_q[22:0], take};
			end else if (cnt_q == 5'h01) begin
				speed_q <= (dvs_q == 24'h0 || quo_q[23]) ? 24'sh7fffff : quo_q;
				req_q   <= ramp_d;
			end else begin
				integ_q <= int_d;
				volt_q  <= closed_q ? out_d : req_q;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	frame_wrap_a: assert property (frame_q == LAST_F |=> frame_q == 9'h000)
		else $error("frame did not wrap at period end");
	edge_time_a: assert property (hall_ev |=> last_edge_q == $past(tb_q))
		else $error("edge time not captured");
	sector_period_a: assert property (
		hall_ev |=> sec_per_q == $past(tb_q) - $past(last_edge_q))
		else $error("sector period wrong");
	dir_inc_a: assert property (
		hall_ev && ns != 3'h7 && ns == nxt(sector_q) |=> !dir_q)
		else $error("incremental step not reported as zero");
	rev_count_a: assert property (
		hall_ev && ns == 3'h0 && sector_q == 3'h5 |=> rev_cnt_q == $past(rev_cnt_q) + 24'sh1)
		else $error("revolution count not incremented");
	hall_latency_a: assert property (
		$rose(rq_hall_q) |-> ##[1:40] svc_q == mc_pkg::SV_HALL)
		else $error("hall service waited too long");
	cmd_pair_a: assert property (
		svc_q == mc_pkg::SV_HALL && cnt_q == 5'h01 && en_q ##1 en_q ##1 en_q
		|-> $countones(on_q) == 2)
		else $error("commutation did not leave two phases on");
	sc_pulse_a: assert property ($rose(sc_act) |-> sc_act[*8])
		else $error("speed loop activity pulse too short");
	sc_to_master_a: assert property (sc_done |-> ##[1:40] master_act)
		else $error("master did not serve speed loop result");
	mupd_narrow_a: assert property (
		g_mupd && !pend_q |=> master_act ##1 !master_act)
		else $error("idle update pulse not narrow");

	hall_edge_c: cover property (hall_ev && en_q);
	sc_run_c: cover property (g_sc);
	wide_upd_c: cover property (g_mupd && pend_q);
endmodule // bldc_motor_ctl

// ### hall_sensor_model.sv
`timescale 1ns/1ns
module hall_sensor_model (
	// Clock
	input  wire logic       clk,
	// Step request from the bench
	input  wire logic       step,
	input  wire logic       back,
	// Sensor lines
	output logic      [2:0] hall
);
	// One bit changes per sector, as a real rotor would produce
	localparam logic [2:0] SEQ [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
	int unsigned idx = 0;

	initial hall = 3'h1;

	always @(posedge clk) begin
		if (step) begin
			idx = back ? (idx + 5) % 6 : (idx + 1) % 6;
			hall <= SEQ[idx];
		end
	end
endmodule // hall_sensor_model

// ### bldc_hall_commutation_speed_loop_tb.sv
`timescale 1ns/1ns
module bldc_hall_commutation_speed_loop_tb;
	// Run length kept well above the roughly 28k cycles of the sequence
	localparam int         LIMIT    = 40000;
	localparam logic [2:0] MASK [3] = '{3'h3, 3'h5, 3'h6};
	logic        clk = 0;
	logic        rst = 1;
	logic        wr = 0;
	logic        rd = 0;
	logic        step = 0;
	logic        back = 0;
	logic        seen_clr = 0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata, d, e1, rc0;
	logic [2:0]  hall, pb, pcmp;
	logic [2:0]  seen = 3'h0;
	logic        sc_act, master_act;
	int cyc = 0, t_last = 0, sc_w = 0, sc_n = 0, sc_len = 0, sc_per = 0, sc_t = 0;
	int m_w = 0, m_n = 0, m3_n = 0, m_k = 0, gap = 0, pc_bad = 0, ovl = 0;
	int n_fail = 0, compares = 0, s0, m0, w0;

	bldc_motor_ctl dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .hall(hall), .phase_base(pb), .phase_comp(pcmp),
		.sc_act(sc_act), .master_act(master_act));
	hall_sensor_model hall_u (.clk(clk), .step(step), .back(back), .hall(hall));

	always #50 clk = ~clk;

	// Pulse bookkeeping for the activity pins and phase pins
	always @(posedge clk) begin
		cyc <= cyc + 1;
		seen <= seen_clr ? 3'h0 : (seen | pb);
		if (pcmp !== pb) pc_bad <= pc_bad + 1;
		if (sc_act && master_act) ovl <= ovl + 1;
		sc_w <= sc_act ? sc_w + 1 : 0;
		m_w <= master_act ? m_w + 1 : 0;
		if (!sc_act && sc_w != 0) begin
			sc_n <= sc_n + 1;
			sc_len <= sc_w;
		end
		if (sc_act && sc_w == 0) begin
			sc_per <= cyc - sc_t;
			sc_t <= cyc;
			m_k <= 0;
		end
		if (master_act && m_w == 0) begin
			m_n <= m_n + 1;
			m_k <= m_k + 1;
			if (m_k == 1) gap <= cyc - sc_t;
		end
		if (!master_act && m_w == 3) m3_n <= m3_n + 1;
		if (cyc >= LIMIT) begin
			fail("cycle limit reached");
			print_verdict();
		end
	end

	task automatic fail(input string m);
		$display("mismatch at %0t: %s", $time, m);
		n_fail++;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) fail($sformatf("got %h expected %h", got, exp));
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		wr <= 1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 0;
	endtask

	// Data stands only in the cycle after the strobe
	task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		rd <= 1;
		addr <= a;
		@(posedge clk);
		rd <= 0;
		#1 v = rdata;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		reg_rd(a, d);
		chk(d, exp);
	endtask

	// Always step on an edge, so gaps count whole cycles from the last step
	task automatic hstep(input logic bk, input int g);
		@(posedge clk);
		while (cyc < t_last + g) @(posedge clk);
		step <= 1;
		back <= bk;
		t_last = cyc;
		@(posedge clk);
		step <= 0;
	endtask

	task automatic wait_sc(input int n);
		int k0;
		int lim;
		k0 = sc_n;
		lim = 0;
		while (sc_n < k0 + n && lim < 3000 * n) begin
			@(posedge clk);
			lim++;
		end
		if (lim >= 3000 * n) fail("speed loop did not run");
		repeat (3) @(posedge clk);
	endtask

	task automatic print_verdict();
		$display("fails %0d, compares %0d", n_fail, compares);
		if (n_fail == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		repeat (3) @(posedge clk);
		rst <= 0;
		rchk(mc_pkg::A_CTRL, 32'h0);
		rchk(mc_pkg::A_KP, {8'h0, mc_pkg::KP_RST});
		rchk(mc_pkg::A_KI, {8'h0, mc_pkg::KI_RST});
		rchk(mc_pkg::A_STEP, {8'h0, mc_pkg::STEP_RST});
		rchk(mc_pkg::A_LEAD, {23'h0, mc_pkg::LEAD_RST});
		rchk(mc_pkg::A_SCOFS, {23'h0, mc_pkg::SCOFS_RST});
		rchk(mc_pkg::A_SCALE, {8'h0, mc_pkg::SCALE_RST});
		reg_wr(8'h3c, 32'hffffffff);
		rchk(8'h3c, 32'h0);
		chk({29'h0, seen}, 32'h0);
		reg_wr(mc_pkg::A_SETP, 32'h0);
		reg_wr(mc_pkg::A_CTRL, 32'h1);
		reg_rd(mc_pkg::A_REVCNT, rc0);
		t_last = cyc;
		// First revolution slow enough to see a whole frame per sector
		for (int k = 1; k <= 6; k++) begin
			hstep(1'b0, 600);
			repeat (50) @(posedge clk);
			seen_clr <= 1;
			@(posedge clk);
			seen_clr <= 0;
			reg_rd(mc_pkg::A_STAT, d);
			chk({28'h0, d[3:0]}, k % 6);
			while (cyc < t_last + 590) @(posedge clk);
			chk({29'h0, seen}, {29'h0, MASK[k % 3]});
		end
		reg_rd(mc_pkg::A_REVCNT, d);
		chk({8'h0, d[23:0] - rc0[23:0]}, 32'h1);
		// Six even steps, so the next revolution spans only known gaps
		for (int k = 1; k <= 6; k++) hstep(1'b0, 200);
		reg_rd(mc_pkg::A_EDGE, e1);
		hstep(1'b0, 260);
		repeat (3) @(posedge clk);
		reg_rd(mc_pkg::A_EDGE, d);
		chk({8'h0, d[23:0] - e1[23:0]}, 32'd260);
		rchk(mc_pkg::A_REVPER, 32'd1260);
		rchk(mc_pkg::A_SECPER, 32'd260);
		reg_rd(mc_pkg::A_REVCNT, d);
		chk({8'h0, d[23:0] - rc0[23:0]}, 32'h2);
		wait_sc(2);
		rchk(mc_pkg::A_SPEED, {8'h0, mc_pkg::SCALE_RST} / 1260);
		reg_wr(mc_pkg::A_CTRL, 32'h5);
		wait_sc(2);
		rchk(mc_pkg::A_SPEED, {8'h0, mc_pkg::SCALE_RST} / 1560);
		reg_wr(mc_pkg::A_CTRL, 32'h1);
		wait_sc(1);
		s0 = sc_n;
		m0 = m_n;
		w0 = m3_n;
		repeat (5000) @(posedge clk);
		chk(sc_n - s0, 5);
		chk(m_n - m0, 15);
		chk(m3_n - w0, 5);
		chk(sc_len, mc_pkg::SC_LEN);
		chk(sc_per, 2 * mc_pkg::PERIOD_CYC);
		chk(gap, {23'h0, mc_pkg::SCOFS_RST});
		reg_wr(mc_pkg::A_SCOFS, 32'h50);
		wait_sc(2);
		chk(gap, 32'h50);
		// Open loop: applied voltage follows the ramp one step per run
		reg_wr(mc_pkg::A_CTRL, 32'h0);
		reg_wr(mc_pkg::A_STEP, 32'h400);
		reg_wr(mc_pkg::A_SETP, 32'h1000);
		reg_wr(mc_pkg::A_CTRL, 32'h1);
		wait_sc(1);
		rchk(mc_pkg::A_VOLT, 32'h400);
		wait_sc(1);
		rchk(mc_pkg::A_VOLT, 32'h800);
		wait_sc(3);
		rchk(mc_pkg::A_VOLT, 32'h1000);
		reg_wr(mc_pkg::A_CTRL, 32'h0);
		reg_wr(mc_pkg::A_KP, 32'h7fffff);
		reg_wr(mc_pkg::A_STEP, 32'h7fffff);
		reg_wr(mc_pkg::A_SETP, 32'h7fffff);
		reg_wr(mc_pkg::A_CTRL, 32'h3);
		wait_sc(2);
		rchk(mc_pkg::A_VOLT, 32'h7fffff);
		reg_wr(mc_pkg::A_SETP, 32'h800000);
		wait_sc(3);
		rchk(mc_pkg::A_VOLT, 32'h800000);
		reg_wr(mc_pkg::A_CTRL, 32'h1);
		t_last = cyc;
		for (int k = 1; k <= 6; k++) hstep(1'b1, 200);
		repeat (3) @(posedge clk);
		reg_rd(mc_pkg::A_STAT, d);
		chk({28'h0, d[3:0]}, 32'h9);
		reg_rd(mc_pkg::A_REVCNT, d);
		chk({8'h0, d[23:0] - rc0[23:0]}, 32'h1);
		chk(pc_bad, 0);
		chk(ovl, 0);
		print_verdict();
	end
endmodule // bldc_hall_commutation_speed_loop_tb
